//--- tsrel_pkg.sv
package tsrel_pkg;

  // ==========================================================================
  // register pointers
  localparam logic [7:0] REG_FEATURE  = 8'h00;
  localparam logic [7:0] REG_CONTROL  = 8'h01;
  localparam logic [7:0] REG_UPPER    = 8'h02;
  localparam logic [7:0] REG_LOWER    = 8'h03;
  localparam logic [7:0] REG_CRITICAL = 8'h04;
  localparam logic [7:0] REG_MEASURED = 8'h05;
  localparam logic [7:0] REG_MAKER    = 8'h06;
  localparam logic [7:0] REG_PART     = 8'h07;

  // ==========================================================================
  // reset values and masks
  localparam logic [15:0] FEATURE_VALUE  = 16'h007F;
  localparam logic [15:0] WRITABLE_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_MASK     = 16'h1FFC;
  localparam logic [15:0] CONTROL_MASK   = 16'h07CF;
  localparam logic [7:0]  POINTER_RESET  = 8'h00;

  // ==========================================================================
  // field positions
  localparam int CFG_MODE       = 0;
  localparam int CFG_POL        = 1;
  localparam int CFG_CRIT_ONLY  = 2;
  localparam int CFG_ALERT_EN   = 3;
  localparam int CFG_STATUS     = 4;
  localparam int CFG_CLEAR      = 5;
  localparam int CFG_ALARM_LOCK = 6;
  localparam int CFG_CRIT_LOCK  = 7;
  localparam int CFG_SHUTDOWN   = 8;
  localparam int CFG_HYST_LO    = 9;
  localparam int CFG_HYST_HI    = 10;
  localparam int FEAT_SHUTDOWN_BEHAV = 7;
  localparam int TEMP_MSB       = 12;

  // ==========================================================================
  // serial address type code and timing
  localparam logic [3:0] SENSOR_TYPE_CODE = 4'h3;
  localparam int CLK_KHZ              = 250000;
  localparam int CONV_PERIOD_MS       = 100;
  localparam int CONV_PERIOD_CYCLES   = CONV_PERIOD_MS * CLK_KHZ;
  localparam int BUS_TIMEOUT_MS       = 25;
  localparam int BUS_TIMEOUT_CYCLES   = BUS_TIMEOUT_MS * CLK_KHZ;

  // ==========================================================================
  // serial engine states
  typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK} tsrel_bus_e;

endpackage

//--- tsrel_sync.sv
module tsrel_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ==========================================================================
  // two flops per bit; stage1 feeds nothing but stage two
  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          stage1[i]   <= RESET_VAL[i];
          sync_out[i] <= RESET_VAL[i];
        end
        else
        begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

//--- tsrel_conv.sv
module tsrel_conv #(
  parameter int PERIOD = tsrel_pkg::CONV_PERIOD_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic shutdown,
  output logic      start
);

  localparam int CW = $clog2(PERIOD + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_start;

  // ==========================================================================
  // free-running period; a held-off count restarts at once on wake-up
  always_comb
  begin
    next_count = count;
    next_start = 1'b0;
    if (shutdown)
      next_count = '0;
    else if (count == '0)
    begin
      next_start = 1'b1;
      next_count = CW'(PERIOD - 1);
    end
    else
      next_count = count - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= '0;
      start <= 1'b0;
    end
    else
    begin
      count <= next_count;
      start <= next_start;
    end
  end

  a_conv_period: assert property (@(posedge clk) disable iff (srst)
    start |=> !start)
    else $error("conversion start lasted more than one cycle");

endmodule

//--- tsrel_top.sv
// Function
// - start a new conversion every 100 ms, and at once on wake-up from shutdown
// - latch each result; hold the reading frozen during shutdown
// - host reads never disturb the conversion sequence
// - compare reading with high, low and critical limits to drive alert
// - writable registers reset to zero; host programs them later
// - alert disabled, polarity low after reset
// - limit writes re-evaluate alert at once while sensor enabled
// - eight 16-bit registers at pointers 0 to 7
// - pointer selects feature register after reset
// - limits are two's complement with 0.25 degree lsb
// - reading in bits 12:0, sign at bit 12, lsb 0.0625 degree
// - bits 15:13 show trip results regardless of alert settings
// - critical at or above; high strictly above; low strictly below
// - feature register read-only 0x007F, upper byte zero
// - feature bit 7 picks freeze or clear of status at shutdown
// - clear bit releases frozen status in shutdown; never sets then
// - feature bits 4:3 give resolution, 11 for 0.0625 degree
// - feature bit 6 marks bus timeout between 25 and 35 ms
// - feature bits 2, 0 and 5 mark sign, interrupt, high-voltage
// - fixed maker id at 6, part and revision id at 7
// - clear bit works in interrupt mode, not past critical; reads 0
// - lock bits sticky to reset; block limits and mode changes
module tsrel_top #(
  parameter int          CONV_PERIOD_CYCLES = tsrel_pkg::CONV_PERIOD_CYCLES,
  parameter int          BUS_TIMEOUT_CYCLES = tsrel_pkg::BUS_TIMEOUT_CYCLES,
  parameter logic [15:0] MAKER_ID           = 16'h5A5A, // arbitrary value
  parameter logic [15:0] PART_REV_ID        = 16'hC3C3  // arbitrary value
) (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic [2:0]  ADDR_SEL,
  output logic             CONV_START,
  input  wire logic        CONV_DONE,
  input  wire logic [12:0] CONV_DATA,
  output logic             EVENT_OUT,
  output logic             EVENT_OE_N
);

  localparam int TW = $clog2(BUS_TIMEOUT_CYCLES + 1);

  logic [4:0]  pins_s;
  logic        scl_s, sda_s, scl_q, sda_q;
  logic        scl_rise, scl_fall, bus_start, bus_stop;
  tsrel_pkg::tsrel_bus_e state, next_state;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shift, next_shift, pointer, next_pointer, wr_msb, next_wr_msb;
  logic [1:0]  byte_idx, next_byte_idx;
  logic        read_mode, next_read_mode, tx_low, next_tx_low;
  logic        next_sda_oe_n, wr_en, next_wr_en, addr_hit;
  logic [15:0] tx_word, next_tx_word, rd_word, wr_word;
  logic [7:0]  tx_byte;
  logic [TW-1:0] idle_cnt, next_idle_cnt;
  logic [15:0] cfg, next_cfg, upper, next_upper, lower, next_lower, crit, next_crit;
  logic [12:0] temp, next_temp;
  logic        temp_valid, next_temp_valid, shutdown, any_lock, clear_req;
  logic        crit_trip, high_trip, low_trip, cond, prev_cond, next_prev_cond;
  logic        status, next_status, next_event_oe_n, shutdown_alert_behaviour;

  // ==========================================================================
  // pin synchronisers and conversion pacing
  tsrel_sync #(.WIDTH(5), .RESET_VAL(5'h1F)) u_sync (
    .clk      (CLOCK),
    .srst     (SRST),
    .async_in ({ADDR_SEL, SDA_IN, SCL}),
    .sync_out (pins_s)
  );

  // conversion runs on its own counter; bus traffic touches it only through the shutdown bit
  tsrel_conv #(.PERIOD(CONV_PERIOD_CYCLES)) u_conv (
    .clk      (CLOCK),
    .srst     (SRST),
    .shutdown (shutdown),
    .start    (CONV_START)
  );

  // ==========================================================================
  // serial engine
  assign scl_s     = pins_s[0];
  assign sda_s     = pins_s[1];
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign addr_hit  = (shift[7:4] == tsrel_pkg::SENSOR_TYPE_CODE) && (shift[3:1] == pins_s[4:2]);
  assign tx_byte   = tx_low ? tx_word[7:0] : tx_word[15:8];
  assign wr_word   = {wr_msb, shift};

  // byte framing, ack slots, pointer and write capture
  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_byte_idx  = byte_idx;
    next_read_mode = read_mode;
    next_pointer   = pointer;
    next_wr_msb    = wr_msb;
    next_tx_word   = tx_word;
    next_tx_low    = tx_low;
    next_sda_oe_n  = SDA_OE_N;
    next_wr_en     = 1'b0;
    next_idle_cnt  = (state != tsrel_pkg::BUS_IDLE && !scl_s) ? idle_cnt + 1'b1 : '0;
    if (bus_start)
    begin
      next_state    = tsrel_pkg::BUS_RX;
      next_bit_cnt  = 4'h0;
      next_byte_idx = 2'h0;
      next_sda_oe_n = 1'b1;
    end
    // a stalled master is dropped once the clock stays low too long
    else if (bus_stop || idle_cnt == TW'(BUS_TIMEOUT_CYCLES))
    begin
      next_state    = tsrel_pkg::BUS_IDLE;
      next_sda_oe_n = 1'b1;
    end
    else
    begin
      case (state)
        tsrel_pkg::BUS_RX:
          if (scl_rise)
          begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == 4'h8)
          begin
            next_bit_cnt = 4'h0;
            if (byte_idx != 2'h0 || addr_hit)
            begin
              next_state    = tsrel_pkg::BUS_RX_ACK;
              next_sda_oe_n = 1'b0;
              case (byte_idx)
                2'h0:    next_read_mode = shift[0];
                2'h1:    next_pointer = shift;
                2'h2:    next_wr_msb = shift;
                default: next_wr_en = 1'b1;
              endcase
            end
            else
              next_state = tsrel_pkg::BUS_IDLE;
          end
        tsrel_pkg::BUS_RX_ACK:
          if (scl_fall)
          begin
            if (byte_idx == 2'h0 && read_mode)
            begin
              // snapshot whole word so both bytes match
              next_state    = tsrel_pkg::BUS_TX;
              next_tx_word  = rd_word;
              next_tx_low   = 1'b0;
              next_sda_oe_n = rd_word[15];
              next_bit_cnt  = 4'h1;
            end
            else
            begin
              next_state    = tsrel_pkg::BUS_RX;
              next_sda_oe_n = 1'b1;
              next_byte_idx = (byte_idx == 2'h3) ? 2'h2 : byte_idx + 2'h1;
            end
          end
        tsrel_pkg::BUS_TX:
          if (scl_fall)
          begin
            if (bit_cnt == 4'h8)
            begin
              next_state    = tsrel_pkg::BUS_TX_ACK;
              next_sda_oe_n = 1'b1;
            end
            else
            begin
              next_sda_oe_n = tx_byte[~bit_cnt[2:0]];
              next_bit_cnt  = bit_cnt + 4'h1;
            end
          end
        tsrel_pkg::BUS_TX_ACK:
          if (scl_rise && sda_s)
            next_state = tsrel_pkg::BUS_IDLE;
          else if (scl_fall)
          begin
            next_state   = tsrel_pkg::BUS_TX;
            next_bit_cnt = 4'h1;
            next_tx_low  = ~tx_low;
            if (tx_low)
            begin
              next_tx_word  = rd_word;
              next_sda_oe_n = rd_word[15];
            end
            else
              next_sda_oe_n = tx_word[7];
          end
        default:
          next_state = tsrel_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      state     <= tsrel_pkg::BUS_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      byte_idx  <= 2'h0;
      read_mode <= 1'b0;
      pointer   <= tsrel_pkg::POINTER_RESET;
      wr_msb    <= 8'h00;
      tx_word   <= 16'h0000;
      tx_low    <= 1'b0;
      wr_en     <= 1'b0;
      idle_cnt  <= '0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      SDA_OE_N  <= 1'b1;
      SDA_OUT   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      byte_idx  <= next_byte_idx;
      read_mode <= next_read_mode;
      pointer   <= next_pointer;
      wr_msb    <= next_wr_msb;
      tx_word   <= next_tx_word;
      tx_low    <= next_tx_low;
      wr_en     <= next_wr_en;
      idle_cnt  <= next_idle_cnt;
      scl_q     <= scl_s;
      sda_q     <= sda_s;
      SDA_OE_N  <= next_sda_oe_n;
      SDA_OUT   <= 1'b0;
    end
  end

  // ==========================================================================
  // register file
  assign shutdown  = cfg[tsrel_pkg::CFG_SHUTDOWN];
  assign any_lock  = cfg[tsrel_pkg::CFG_ALARM_LOCK] | cfg[tsrel_pkg::CFG_CRIT_LOCK];
  assign clear_req = wr_en && pointer == tsrel_pkg::REG_CONTROL && wr_word[tsrel_pkg::CFG_CLEAR];
  assign shutdown_alert_behaviour = tsrel_pkg::FEATURE_VALUE[tsrel_pkg::FEAT_SHUTDOWN_BEHAV];

  // read mux; unmapped pointers read zero
  always_comb
  begin
    case (pointer)
      tsrel_pkg::REG_FEATURE:  rd_word = tsrel_pkg::FEATURE_VALUE;
      tsrel_pkg::REG_CONTROL:  rd_word = cfg | (16'(status) << tsrel_pkg::CFG_STATUS);
      tsrel_pkg::REG_UPPER:    rd_word = upper;
      tsrel_pkg::REG_LOWER:    rd_word = lower;
      tsrel_pkg::REG_CRITICAL: rd_word = crit;
      tsrel_pkg::REG_MEASURED: rd_word = {crit_trip, high_trip, low_trip, temp};
      tsrel_pkg::REG_MAKER:    rd_word = MAKER_ID;
      tsrel_pkg::REG_PART:     rd_word = PART_REV_ID;
      default:                 rd_word = 16'h0000;
    endcase
  end

  // writes honour locks; a frozen reading ignores results
  always_comb
  begin
    next_cfg        = cfg;
    next_upper      = upper;
    next_lower      = lower;
    next_crit       = crit;
    next_temp       = temp;
    next_temp_valid = temp_valid;
    if (CONV_DONE && !shutdown)
    begin
      next_temp       = CONV_DATA;
      next_temp_valid = 1'b1;
    end
    if (wr_en)
    begin
      case (pointer)
        tsrel_pkg::REG_CONTROL:
        begin
          next_cfg = wr_word & tsrel_pkg::CONTROL_MASK;
          next_cfg[tsrel_pkg::CFG_ALARM_LOCK] = wr_word[6] | cfg[6];
          next_cfg[tsrel_pkg::CFG_CRIT_LOCK]  = wr_word[7] | cfg[7];
          if (cfg[tsrel_pkg::CFG_ALARM_LOCK])
            next_cfg[tsrel_pkg::CFG_CRIT_ONLY] = wr_word[2] & cfg[2];
          if (any_lock)
          begin
            next_cfg[1:0]  = cfg[1:0];
            next_cfg[3]    = cfg[3];
            next_cfg[10:9] = cfg[10:9];
            next_cfg[8]    = wr_word[8] & cfg[8];
          end
        end
        tsrel_pkg::REG_UPPER:
          if (!cfg[tsrel_pkg::CFG_ALARM_LOCK])
            next_upper = wr_word & tsrel_pkg::LIMIT_MASK;
        tsrel_pkg::REG_LOWER:
          if (!cfg[tsrel_pkg::CFG_ALARM_LOCK])
            next_lower = wr_word & tsrel_pkg::LIMIT_MASK;
        tsrel_pkg::REG_CRITICAL:
          if (!cfg[tsrel_pkg::CFG_CRIT_LOCK])
            next_crit = wr_word & tsrel_pkg::LIMIT_MASK;
        default: ; // read-only and unmapped pointers ignore writes
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      cfg        <= tsrel_pkg::WRITABLE_RESET;
      upper      <= tsrel_pkg::WRITABLE_RESET;
      lower      <= tsrel_pkg::WRITABLE_RESET;
      crit       <= tsrel_pkg::WRITABLE_RESET;
      temp       <= 13'h0000;
      temp_valid <= 1'b0;
    end
    else
    begin
      cfg        <= next_cfg;
      upper      <= next_upper;
      lower      <= next_lower;
      crit       <= next_crit;
      temp       <= next_temp;
      temp_valid <= next_temp_valid;
    end
  end

  // ==========================================================================
  // trip compare and alert; live compare lets limit writes act at once
  assign crit_trip = temp_valid && $signed(temp) >= $signed(crit[12:0]);
  assign high_trip = temp_valid && $signed(temp) > $signed(upper[12:0]);
  assign low_trip  = temp_valid && $signed(temp) < $signed(lower[12:0]);
  assign cond      = cfg[tsrel_pkg::CFG_CRIT_ONLY] ? crit_trip : (crit_trip | high_trip | low_trip);

  always_comb
  begin
    next_prev_cond = cond;
    next_status    = status;
    if (!cfg[tsrel_pkg::CFG_ALERT_EN])
      next_status = 1'b0;
    else if (shutdown)
    begin
      if (shutdown_alert_behaviour || clear_req)
        next_status = 1'b0;
    end
    else if (!cfg[tsrel_pkg::CFG_MODE])
      next_status = cond;
    else
    begin
      if (clear_req && !crit_trip)
        next_status = 1'b0;
      if (cond && !prev_cond)
        next_status = 1'b1; // new event beats same-cycle clear
    end
    next_event_oe_n = ~(cfg[tsrel_pkg::CFG_POL] ? ~status : status);
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      status     <= 1'b0;
      prev_cond  <= 1'b0;
      EVENT_OE_N <= 1'b1;
      EVENT_OUT  <= 1'b0;
    end
    else
    begin
      status     <= next_status;
      prev_cond  <= next_prev_cond;
      EVENT_OE_N <= next_event_oe_n;
      EVENT_OUT  <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  logic [31:0] gap;
  always_ff @(posedge CLOCK)
  begin
    if (SRST || CONV_START || shutdown)
      gap <= 32'h0000_0000;
    else
      gap <= gap + 32'h0000_0001;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  a_conv_gap_bound: assert property (gap <= 32'(CONV_PERIOD_CYCLES))
    else $error("conversion start gap too long");
  a_reading_frozen: assert property (shutdown |=> $stable(temp))
    else $error("reading changed during shutdown");
  a_event_idle_init: assert property (!cfg[3] && !cfg[1] ##1 !cfg[1] |=> EVENT_OE_N)
    else $error("event pin active while disabled");
  a_crit_lock_hold: assert property (cfg[7] |=> $stable(crit) && cfg[7])
    else $error("critical limit changed under lock");
  a_alarm_lock_hold: assert property (cfg[6] |=> $stable(upper) && $stable(lower))
    else $error("alarm limit changed under lock");
  a_no_set_shutdown: assert property (shutdown && !status |=> !status)
    else $error("status set during shutdown");
  a_crit_clear_block: assert property (cfg[0] && cfg[3] && !shutdown && crit_trip && status |=> status)
    else $error("status cleared past critical");
  a_limit_format: assert property (upper[1:0] == 2'b00 && crit[15:13] == 3'b000)
    else $error("limit holds unimplemented bits");
  a_comp_follow: assert property (cfg[3] && !cfg[0] && !shutdown && $changed(upper) |=> status == $past(cond))
    else $error("limit write not re-evaluated");
  a_untrip_invalid: assert property (!temp_valid |-> !crit_trip && !high_trip && !low_trip)
    else $error("trip without valid reading");

  c_read_word: cover property (state == tsrel_pkg::BUS_TX && tx_low);
  c_write_word: cover property (wr_en && pointer == tsrel_pkg::REG_UPPER);
  c_alert_on: cover property ($fell(EVENT_OE_N));
  c_shutdown_clear: cover property (shutdown && clear_req && status);

endmodule

//--- tsrel_host.sv
// ==========================================================
// serial host: controller side of the two-wire bus
module tsrel_host (
  output logic            scl,
  output logic            sda_low,
  input  wire logic       sda,
  input  wire logic [2:0] addr
);
  timeunit 1ns;
  timeprecision 100ps;
  int nacks = 0;
  int slow = 0;
  // idle: clock stands high, data released to the pull-up
  initial {scl, sda_low} = 2'b10;
  // data moves late in the low phase so it never races the device's ack release
  task automatic bit_io(input logic b, output logic r);
    #(12 + slow) sda_low = !b;
    #10 scl = 1'b1;
    #10 r = sda;
    scl = 1'b0;
  endtask
  // one byte plus ack slot; on writes a missing device ack is counted
  task automatic xfer(input logic wr, input logic [7:0] d, input logic nak, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(wr || nak, a);
    if (wr)
      nacks += int'(a !== 1'b0);
  endtask
  // start or repeated start, then the address byte
  task automatic start(input logic rd);
    logic [7:0] q;
    #16 sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
    xfer(1'b1, {tsrel_pkg::SENSOR_TYPE_CODE, addr, rd}, 1'b0, q);
  endtask
  task automatic stop();
    #16 sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #16;
  endtask
  // pointer, then the word high byte first
  task automatic write_reg(input logic [7:0] p, input logic [15:0] d);
    logic [7:0] q;
    start(1'b0);
    xfer(1'b1, p, 1'b0, q);
    xfer(1'b1, d[15:8], 1'b0, q);
    xfer(1'b1, d[7:0], 1'b0, q);
    stop();
  endtask
  // optional pointer, repeated start, ack high byte, nack low byte
  task automatic read_reg(input logic [7:0] p, input logic setp, output logic [15:0] d);
    if (setp)
    begin
      start(1'b0);
      xfer(1'b1, p, 1'b0, d[7:0]);
    end
    start(1'b1);
    xfer(1'b0, 8'hFF, 1'b0, d[15:8]);
    xfer(1'b0, 8'hFF, 1'b1, d[7:0]);
    stop();
  endtask
endmodule

//--- tsrel_top_tb.sv
// ==========================================================
// bench: register traffic through the host model
module tsrel_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PERIOD = 200;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        conv_done = 1'b0;
  logic [12:0] conv_data = 13'h0000;
  logic [12:0] temp = 13'h0190;
  logic [2:0]  addr_sel = 3'h5;
  logic        hold = 1'b0;
  logic        shut = 1'b0;
  logic [15:0] rd;
  wire         scl, sda_low, sda, sda_out, sda_oe_n, conv_start, event_out, event_oe_n, event_pin;
  int          mismatches = 0;
  int          check_count = 0;
  int          gap = 0;
  int          max_gap = 0;
  logic [12:0] temps [6] = '{13'h0190, 13'h0191, 13'h0280, 13'h0050, 13'h004F, 13'h1FF0};
  logic [15:0] reads [6] = '{16'h0190, 16'h4191, 16'hC280, 16'h0050, 16'h204F, 16'h3FF0};
  // both lines have pull-ups, so a released line reads high
  assign sda = !(sda_low || (!sda_oe_n && !sda_out));
  assign event_pin = !(!event_oe_n && !event_out);
  // 250 MHz system clock
  always #2 clock = ~clock;
  // front end answers a start next cycle; hold mutes it to isolate limit writes
  always @(posedge clock)
  begin
    conv_done <= conv_start && !hold;
    conv_data <= temp;
    gap <= (conv_start || shut || srst) ? 0 : gap + 1;
    if (gap > max_gap)
      max_gap <= gap;
  end
  tsrel_top #(
    .CONV_PERIOD_CYCLES (PERIOD),
    .BUS_TIMEOUT_CYCLES (2000),
    .MAKER_ID           (16'h1234), // arbitrary value
    .PART_REV_ID        (16'h4321)  // arbitrary value
  ) u_dut (
    .CLOCK      (clock),
    .SRST       (srst),
    .SCL        (scl),
    .SDA_IN     (sda),
    .SDA_OUT    (sda_out),
    .SDA_OE_N   (sda_oe_n),
    .ADDR_SEL   (addr_sel),
    .CONV_START (conv_start),
    .CONV_DONE  (conv_done),
    .CONV_DATA  (conv_data),
    .EVENT_OUT  (event_out),
    .EVENT_OE_N (event_oe_n)
  );
  tsrel_host u_host (
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda),
    .addr    (addr_sel)
  );
  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic ev(input logic e);
    chk({15'h0, event_pin}, {15'h0, e});
  endtask
  // start off the clock edge so pin changes never tie with sampling
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge clock);
    #0.7;
    u_host.write_reg(p, d);
  endtask
  task automatic rr(input logic [7:0] p, input logic [15:0] e, input logic [15:0] m = 16'hFFFF, input logic s = 1);
    @(posedge clock);
    #0.7;
    u_host.read_reg(p, s, rd);
    chk(rd & m, e);
  endtask
  // new reading, then wait for the next completed conversion
  task automatic conv(input logic [12:0] t);
    int n;
    n = 0;
    @(posedge clock);
    temp <= t;
    @(posedge clock);
    do
    begin
      @(negedge clock);
      n++;
    end
    while (conv_done !== 1'b1 && n < 3 * PERIOD);
    chk({15'h0, conv_done}, 16'h1);
    repeat (4) @(posedge clock);
  endtask
  task automatic results();
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    chk({14'h0, sda_oe_n, event_oe_n}, 16'h3);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    rr(8'h00, 16'h007F, 16'hFFFF, 1'b0);
    for (int p = 1; p < 5; p++)
      rr(8'(p), 16'h0000, 16'hFFEF);
    wr(8'h00, 16'hFFFF);
    rr(8'h00, 16'h007F);
    rr(8'h06, 16'h1234);
    rr(8'h07, 16'h4321);
    rr(8'h09, 16'h0000);
    wr(8'h02, 16'hE193);
    wr(8'h03, 16'h0050);
    wr(8'h04, 16'h0280);
    rr(8'h02, 16'h0190);
    for (int i = 0; i < 6; i++)
    begin
      conv(temps[i]);
      rr(8'h05, reads[i]);
    end
    wr(8'h01, 16'h0008);
    ev(1'b0);
    rr(8'h01, 16'h0018);
    wr(8'h01, 16'h000A);
    ev(1'b1);
    conv(13'h0100);
    ev(1'b0);
    hold <= 1'b1;
    wr(8'h02, 16'h00F0);
    ev(1'b1);
    hold <= 1'b0;
    conv(13'h00A0);
    wr(8'h01, 16'h0009);
    ev(1'b1);
    conv(13'h0100);
    conv(13'h00A0);
    ev(1'b0);
    wr(8'h01, 16'h0029);
    ev(1'b1);
    rr(8'h01, 16'h0009);
    conv(13'h0300);
    wr(8'h01, 16'h0029);
    ev(1'b0);
    conv(13'h00A0);
    shut <= 1'b1;
    wr(8'h01, 16'h0109);
    ev(1'b0);
    temp <= 13'h0300;
    repeat (3 * PERIOD) @(posedge clock);
    rr(8'h05, 16'h00A0);
    wr(8'h01, 16'h0129);
    ev(1'b1);
    wr(8'h03, 16'h00C0);
    ev(1'b1);
    rr(8'h05, 16'h20A0);
    wr(8'h01, 16'h0009);
    shut <= 1'b0;
    u_host.slow = 40;
    rr(8'h03, 16'h00C0);
    u_host.slow = 0;
    wr(8'h01, 16'h00C9);
    wr(8'h02, 16'h0100);
    rr(8'h02, 16'h00F0);
    wr(8'h04, 16'h0100);
    rr(8'h04, 16'h0280);
    wr(8'h01, 16'h0100);
    rr(8'h01, 16'h00C9, 16'hFFEF);
    @(posedge clock);
    srst <= 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    rr(8'h00, 16'h007F, 16'hFFFF, 1'b0);
    rr(8'h01, 16'h0000, 16'hFFEF);
    ev(1'b1);
    // critical-only trigger: high trip alone must not raise the event
    wr(8'h01, 16'h000C);
    ev(1'b0);
    rr(8'h01, 16'h001C);
    wr(8'h04, 16'h0400);
    ev(1'b1);
    rr(8'h05, 16'h4300);
    chk(16'(max_gap < PERIOD), 16'h0001);
    chk(16'(u_host.nacks), 16'h0000);
    results();
  end
  // watchdog well past the expected run length
  initial
  begin
    #300000;
    mismatches++;
    results();
  end
endmodule
